// File: design/pcisf_regs.svh
`ifndef PCISF_REGS_SVH
`define PCISF_REGS_SVH
// Summary of operation
// - writing one clears a flag, zero leaves it, reads have no side effects
// - bit 15 sets on any detected address or data parity error
// - bit 14 sets when system error is enabled and actually signaled
// - bit 13 sets when our initiated cycle ends in master abort
// - bit 12 sets when our initiated cycle gets a target abort
// - bit 11 sets when we, as target, issue a target abort
// - bits 10 to 9 read the constant medium select timing code 01b
// - bit 8 sets on master data parity error with error line and response enabled
// - bit 7, fast back-to-back capable, always reads zero
// - bit 6, user feature support, reads zero and ignores writes
// - bit 5, high speed capable, reads zero since bus clock is 33 MHz
// - bit 4 always reads one, capability list is present
// - bits 3 to 0 are reserved, read zero and ignore writes
// - address parity reported on system error only with both enables set
// - data parity drives the parity error line, address parity the system error line

`define PCISF_STATUS_OFFSET   8'h06
`define PCISF_STATUS_RESET    16'h0210
`define PCISF_BIT_DET_PAR     15
`define PCISF_BIT_SIG_SERR    14
`define PCISF_BIT_RCV_MABT    13
`define PCISF_BIT_RCV_TABT    12
`define PCISF_BIT_SIG_TABT    11
`define PCISF_SEL_TIMING_HI   10
`define PCISF_SEL_TIMING_LO   9
`define PCISF_SEL_TIMING_CODE 2'b01
`define PCISF_BIT_MST_DPAR    8
`define PCISF_BIT_B2B_CAP     7
`define PCISF_BIT_USER_FEAT   6
`define PCISF_BIT_HS_CAP      5
`define PCISF_BIT_CAP_LIST    4
`define PCISF_RSVD_HI         3
`define PCISF_RSVD_LO         0
`define PCISF_NUM_FLAGS       6
`define PCISF_DRIVE_CYCLES    4'h1
`endif

// File: design/pcisf_pkg.sv
package pcisf_pkg;
  typedef logic [15:0] pcisf_word_t;
  typedef logic [5:0]  pcisf_flags_t;
  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_RESP
  } pcisf_acc_state_t;

  // expand two byte enables to a 16-bit lane mask
  function automatic pcisf_word_t pcisf_lane_mask(input logic [1:0] be);
    pcisf_lane_mask = {{8{be[1]}}, {8{be[0]}}};
  endfunction
endpackage

// File: design/pcisf_sync2.sv
module pcisf_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  input  wire logic [WIDTH-1:0] reset_val_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  if (WIDTH < 1) begin : g_width_check
    $error("pcisf_sync2: WIDTH must be at least 1");
  end

  // second flop alone reads the first
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      meta_q <= reset_val_i;
      sync_q <= reset_val_i;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule // pcisf_sync2

// File: design/pcisf_flag.sv
module pcisf_flag (
  input  wire logic mclk_i,
  input  wire logic reset_n_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_o
);
  logic flag_q;
  logic flag_d;

  // set beats clear one clears, otherwise hold
  assign flag_d = set_i | (flag_q & ~clr_i);

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag_o = flag_q;
endmodule // pcisf_flag

// File: design/pcisf_status_top.sv
`include "pcisf_regs.svh"

module pcisf_status_top
  import pcisf_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  // configuration access port
  input  wire logic        cfg_req_i,
  input  wire logic        cfg_wr_i,
  input  wire logic [7:0]  cfg_offset_i,
  input  wire logic [1:0]  cfg_be_i,
  input  wire logic [15:0] cfg_wdata_i,
  output logic             cfg_ack_o,
  output logic             cfg_hit_o,
  output logic      [15:0] cfg_rdata_o,
  // command register enables
  input  wire logic        system_error_enable_i,
  input  wire logic        parity_response_enable_i,
  // events from target and initiator logic
  input  wire logic        addr_parity_err_i,
  input  wire logic        data_parity_err_i,
  input  wire logic        master_busy_i,
  input  wire logic        master_abort_i,
  input  wire logic        target_abort_rcvd_i,
  input  wire logic        target_abort_sent_i,
  // parity error pin, driven low only, released without driving high
  input  wire logic        perr_n_i,
  output logic             perr_n_o,
  output logic             perr_oe_o,
  // system error pin, open drain
  output logic             serr_n_o,
  output logic             serr_oe_o,
  // live status word
  output logic      [15:0] status_o
);

  // ---------------------------------------------------------------
  // pin input synchroniser
  // ---------------------------------------------------------------
  logic perr_n_sync;

  pcisf_sync2 #(
    .WIDTH (1)
  ) u_perr_sync (
    .mclk_i      (mclk_i),
    .reset_n_i   (reset_n_i),
    .async_i     (perr_n_i),
    .reset_val_i (1'b1),
    .sync_o      (perr_n_sync)
  );

  wire perr_seen_on_pin = ~perr_n_sync;

  // ---------------------------------------------------------------
  // error line drive
  // ---------------------------------------------------------------
  logic perr_drive_q;
  logic perr_drive_d;
  logic serr_drive_q;
  logic serr_drive_d;

  // data parity goes out on the parity error line
  wire perr_request = data_parity_err_i & parity_response_enable_i;
  // address parity needs both enables before system error
  wire serr_request = addr_parity_err_i
                    & system_error_enable_i
                    & parity_response_enable_i;

  assign perr_drive_d = perr_request;
  assign serr_drive_d = serr_request;

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      perr_drive_q <= 1'b0;
      serr_drive_q <= 1'b0;
    end else begin
      perr_drive_q <= perr_drive_d;
      serr_drive_q <= serr_drive_d;
    end
  end

  // parity error line: driven low when enabled, never driven high, idle is left to bus
  assign perr_n_o  = ~perr_drive_q;
  assign perr_oe_o = perr_drive_q;
  // system error line: low only while driven
  assign serr_n_o  = 1'b0;
  assign serr_oe_o = serr_drive_q;

  // ---------------------------------------------------------------
  // flag set conditions
  // ---------------------------------------------------------------
  wire set_det_par  = addr_parity_err_i | data_parity_err_i;
  wire set_sig_serr = serr_drive_q & system_error_enable_i;
  wire set_rcv_mabt = master_abort_i;
  wire set_rcv_tabt = target_abort_rcvd_i;
  wire set_sig_tabt = target_abort_sent_i;

  // our own drive or another agent's, seen while we are master
  wire perr_any     = perr_drive_q | perr_seen_on_pin;
  wire set_mst_dpar = perr_any & master_busy_i
                    & parity_response_enable_i;

  // ---------------------------------------------------------------
  // configuration access decode
  // ---------------------------------------------------------------
  pcisf_acc_state_t acc_state_q;
  pcisf_acc_state_t acc_state_d;
  logic             hit_q;
  logic             hit_d;
  logic [15:0]      rdata_q;
  logic [15:0]      rdata_d;

  wire req_taken    = cfg_req_i & (acc_state_q == ACC_IDLE);
  // 16-bit register at a halfword offset; low address bit ignored
  wire offset_hit   = cfg_offset_i[7:1] == 7'(`PCISF_STATUS_OFFSET >> 1);
  wire status_write = req_taken & cfg_wr_i & offset_hit;
  wire status_read  = req_taken & ~cfg_wr_i & offset_hit;

  // one bits on enabled lanes clear flags
  wire [15:0] clear_mask = cfg_wdata_i & pcisf_lane_mask(cfg_be_i)
                         & {16{status_write}};

  // ---------------------------------------------------------------
  // sticky flags
  // ---------------------------------------------------------------
  pcisf_flags_t flag_set;
  pcisf_flags_t flag_clr;
  pcisf_flags_t flag_val;

  assign flag_set = {set_det_par, set_sig_serr, set_rcv_mabt,
                     set_rcv_tabt, set_sig_tabt, set_mst_dpar};
  assign flag_clr = {clear_mask[`PCISF_BIT_DET_PAR],
                     clear_mask[`PCISF_BIT_SIG_SERR],
                     clear_mask[`PCISF_BIT_RCV_MABT],
                     clear_mask[`PCISF_BIT_RCV_TABT],
                     clear_mask[`PCISF_BIT_SIG_TABT],
                     clear_mask[`PCISF_BIT_MST_DPAR]};

  // each cell lets a same-cycle set win over the clear
  for (genvar i = 0; i < `PCISF_NUM_FLAGS; i++) begin : g_flag
    pcisf_flag u_flag (
      .mclk_i    (mclk_i),
      .reset_n_i (reset_n_i),
      .set_i     (flag_set[i]),
      .clr_i     (flag_clr[i]),
      .flag_o    (flag_val[i])
    );
  end

  wire detected_parity_flag        = flag_val[5];
  wire signaled_system_error_flag  = flag_val[4];
  wire received_master_abort_flag  = flag_val[3];
  wire received_target_abort_flag  = flag_val[2];
  wire signaled_target_abort_flag  = flag_val[1];
  wire master_data_parity_flag     = flag_val[0];

  // ---------------------------------------------------------------
  // hardwired fields
  // ---------------------------------------------------------------
  wire [1:0] select_timing           = `PCISF_SEL_TIMING_CODE;
  wire       back_to_back_capable    = 1'b0;
  wire       user_feature_support    = 1'b0;
  wire       high_speed_capable      = 1'b0;
  wire       capability_list_present = 1'b1;
  wire [3:0] reserved_low            = 4'h0;

  // ---------------------------------------------------------------
  // status word assembly
  // ---------------------------------------------------------------
  wire [15:0] status_word = {
    detected_parity_flag,
    signaled_system_error_flag,
    received_master_abort_flag,
    received_target_abort_flag,
    signaled_target_abort_flag,
    select_timing,
    master_data_parity_flag,
    back_to_back_capable,
    user_feature_support,
    high_speed_capable,
    capability_list_present,
    reserved_low
  };

  // ---------------------------------------------------------------
  // access state machine: request taken in idle, answer next cycle
  // ---------------------------------------------------------------
  always_comb begin
    acc_state_d = acc_state_q;
    hit_d       = hit_q;
    rdata_d     = rdata_q;
    case (acc_state_q)
      ACC_IDLE: begin
        if (req_taken) begin
          acc_state_d = ACC_RESP;
          hit_d       = offset_hit;
          // reads carry no side effect
          rdata_d     = status_read ? status_word : 16'h0000;
        end
      end
      ACC_RESP: begin
        acc_state_d = ACC_IDLE;
      end
      default: begin
        acc_state_d = ACC_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      acc_state_q <= ACC_IDLE;
      hit_q       <= 1'b0;
      rdata_q     <= 16'h0000;
    end else begin
      acc_state_q <= acc_state_d;
      hit_q       <= hit_d;
      rdata_q     <= rdata_d;
    end
  end

  assign cfg_ack_o   = (acc_state_q == ACC_RESP);
  assign cfg_hit_o   = hit_q;
  assign cfg_rdata_o = rdata_q;
  assign status_o    = status_word;

endmodule // pcisf_status_top

// File: bench/pcisf_status_checker.sv
module pcisf_status_checker (
  input wire logic        mclk_i,
  input wire logic        reset_n_i,
  input wire logic        cfg_req_i,
  input wire logic        cfg_wr_i,
  input wire logic [7:0]  cfg_offset_i,
  input wire logic [1:0]  cfg_be_i,
  input wire logic [15:0] cfg_wdata_i,
  input wire logic        cfg_ack_o,
  input wire logic        cfg_hit_o,
  input wire logic [15:0] cfg_rdata_o,
  input wire logic        system_error_enable_i,
  input wire logic        parity_response_enable_i,
  input wire logic        addr_parity_err_i,
  input wire logic        data_parity_err_i,
  input wire logic        master_busy_i,
  input wire logic        master_abort_i,
  input wire logic        target_abort_rcvd_i,
  input wire logic        target_abort_sent_i,
  input wire logic        perr_n_o,
  input wire logic        perr_oe_o,
  input wire logic        serr_n_o,
  input wire logic        serr_oe_o,
  input wire logic [15:0] status_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  wire logic both_en = system_error_enable_i && parity_response_enable_i;
  sequence s_take;
    cfg_req_i && !cfg_ack_o && cfg_offset_i[7:1] == 7'h03;
  endsequence
  sequence s_wclr15;
    s_take ##0 cfg_wr_i && cfg_be_i[1] && cfg_wdata_i[15];
  endsequence
  a_ack_pulse: assert property (s_take |=> cfg_ack_o ##1 !cfg_ack_o)
    else $error("ack not a single pulse");
  a_read_value: assert property (s_take ##0 !cfg_wr_i |=>
    cfg_hit_o && cfg_rdata_o == $past(status_o)) else $error("read data wrong");
  a_write_clear: assert property (s_wclr15 ##0 !addr_parity_err_i &&
    !data_parity_err_i |=> !status_o[15]) else $error("flag 15 not cleared");
  a_fixed_fields: assert property ({status_o[10:9], status_o[7:0]} == 10'h110)
    else $error("constant fields wrong");
  a_parity_sets: assert property ((addr_parity_err_i || data_parity_err_i)
    |=> status_o[15]) else $error("flag 15 not set");
  a_serr_report: assert property (addr_parity_err_i && both_en
    |=> serr_oe_o ##1 status_o[14]) else $error("system error not reported");
  a_serr_quiet: assert property (serr_oe_o |-> $past(addr_parity_err_i && both_en))
    else $error("system error without cause");
  a_master_abort: assert property (master_abort_i |=> status_o[13])
    else $error("flag 13 not set");
  a_tabt_rcvd: assert property (target_abort_rcvd_i |=> status_o[12])
    else $error("flag 12 not set");
  a_tabt_sent: assert property (target_abort_sent_i |=> status_o[11])
    else $error("flag 11 not set");
  a_perr_drive: assert property (data_parity_err_i && parity_response_enable_i
    |=> perr_oe_o && !perr_n_o) else $error("parity line not driven");
  a_dpar_sets: assert property (perr_oe_o && master_busy_i && parity_response_enable_i
    |=> status_o[8]) else $error("flag 8 not set");
  a_dpar_gated: assert property (!status_o[8] && !(master_busy_i &&
    parity_response_enable_i) |=> !status_o[8]) else $error("flag 8 set without cause");
  a_serr_level: assert property (serr_oe_o |-> !serr_n_o)
    else $error("system error line driven high");
endmodule // pcisf_status_checker

// File: bench/pcisf_bus_agent.sv
module pcisf_bus_agent (
  input  wire logic drv_perr_n_i,
  input  wire logic drv_perr_oe_i,
  input  wire logic other_perr_i,
  output logic      perr_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // pulled-up shared line, low while any agent drives it
  assign perr_pin_o = !((drv_perr_oe_i && !drv_perr_n_i) || other_perr_i);
endmodule // pcisf_bus_agent

// File: bench/test_pci_config_status_flags.sv
module test_pci_config_status_flags;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i = 0, reset_n_i = 0, cfg_req_i = 0, cfg_wr_i = 0;
  logic [7:0]  cfg_offset_i = 8'h00;
  logic [1:0]  cfg_be_i = 2'h0;
  logic [15:0] cfg_wdata_i = 16'h0000, cfg_rdata_o, status_o, got;
  logic        system_error_enable_i = 0, parity_response_enable_i = 0;
  logic        addr_parity_err_i = 0, data_parity_err_i = 0, master_busy_i = 0;
  logic        master_abort_i = 0, target_abort_rcvd_i = 0, target_abort_sent_i = 0;
  logic        other = 0, perr_n_i, perr_n_o, perr_oe_o, serr_n_o, serr_oe_o;
  logic        cfg_ack_o, cfg_hit_o, got_hit;
  int          fails = 0, n_compared = 0;
  always #5 mclk_i = ~mclk_i;
  pcisf_status_top i_pcisf_status_top (.mclk_i, .reset_n_i, .cfg_req_i, .cfg_wr_i,
    .cfg_offset_i, .cfg_be_i, .cfg_wdata_i, .cfg_ack_o, .cfg_hit_o, .cfg_rdata_o,
    .system_error_enable_i, .parity_response_enable_i, .addr_parity_err_i,
    .data_parity_err_i, .master_busy_i, .master_abort_i, .target_abort_rcvd_i,
    .target_abort_sent_i, .perr_n_i, .perr_n_o, .perr_oe_o, .serr_n_o, .serr_oe_o,
    .status_o);
  pcisf_bus_agent i_pcisf_bus_agent (.drv_perr_n_i(perr_n_o), .drv_perr_oe_i(perr_oe_o),
    .other_perr_i(other), .perr_pin_o(perr_n_i));
  task automatic acc(input logic w, input logic [7:0] o, input logic [1:0] b,
                     input logic [15:0] d);
    int n;
    n = 0;
    @(negedge mclk_i);
    {cfg_req_i, cfg_wr_i, cfg_offset_i, cfg_be_i, cfg_wdata_i} = {1'b1, w, o, b, d};
    do begin
      @(negedge mclk_i);
      n++;
    end while (cfg_ack_o !== 1'b1 && n < 10);
    chk("ack", 16'h0001, {15'h0000, cfg_ack_o});
    got = cfg_rdata_o;
    got_hit = cfg_hit_o;
    cfg_req_i = 0;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic rdchk(input logic [15:0] e);
    acc(1'b0, 8'h06, 2'h3, 16'h0000);
    chk("status hit", 16'h0001, {15'h0000, got_hit});
    chk("status", e, got);
  endtask
  task automatic pulse(ref logic s);
    @(negedge mclk_i);
    s = 1;
    @(negedge mclk_i);
    s = 0;
    repeat (3) @(negedge mclk_i);
  endtask
  task automatic pin_case(input logic p, input logic m, input logic [15:0] e);
    {parity_response_enable_i, master_busy_i, other} = {p, m, 1'b1};
    repeat (2) @(negedge mclk_i);
    other = 0;
    repeat (4) @(negedge mclk_i);
    rdchk(e);
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #20000;
    fails++;
    complete_run;
  end
  initial begin
    repeat (5) @(negedge mclk_i);
    reset_n_i = 1;
    rdchk(16'h0210);
    $display("test reset done");
    {system_error_enable_i, parity_response_enable_i, master_busy_i} = 3'h7;
    pulse(addr_parity_err_i);
    pulse(data_parity_err_i);
    pulse(master_abort_i);
    pulse(target_abort_rcvd_i);
    pulse(target_abort_sent_i);
    rdchk(16'hfb10);
    rdchk(16'hfb10);
    $display("test event flags done");
    acc(1'b1, 8'h06, 2'h3, 16'h0000);
    rdchk(16'hfb10);
    acc(1'b1, 8'h07, 2'h1, 16'hffff);
    rdchk(16'hfb10);
    acc(1'b1, 8'h06, 2'h2, 16'h4000);
    rdchk(16'hbb10);
    acc(1'b1, 8'h04, 2'h3, 16'hffff);
    acc(1'b0, 8'h04, 2'h3, 16'h0000);
    chk("unmapped hit", 16'h0000, {15'h0000, got_hit});
    chk("unmapped data", 16'h0000, got);
    rdchk(16'hbb10);
    acc(1'b1, 8'h06, 2'h3, 16'hffff);
    rdchk(16'h0210);
    $display("test write clear done");
    system_error_enable_i = 0;
    pulse(addr_parity_err_i);
    rdchk(16'h8210);
    acc(1'b1, 8'h06, 2'h2, 16'h8000);
    pin_case(1'b0, 1'b1, 16'h0210);
    pin_case(1'b1, 1'b0, 16'h0210);
    pin_case(1'b1, 1'b1, 16'h0310);
    $display("test enables done");
    fork
      acc(1'b1, 8'h06, 2'h3, 16'h2100);
      begin
        @(negedge mclk_i);
        master_abort_i = 1;
        @(negedge mclk_i);
        master_abort_i = 0;
      end
    join
    rdchk(16'h2210);
    $display("test set priority done");
    complete_run;
  end
endmodule // test_pci_config_status_flags
bind pcisf_status_top pcisf_status_checker i_pcisf_status_checker (.mclk_i, .reset_n_i,
  .cfg_req_i, .cfg_wr_i, .cfg_offset_i, .cfg_be_i, .cfg_wdata_i, .cfg_ack_o, .cfg_hit_o,
  .cfg_rdata_o, .system_error_enable_i, .parity_response_enable_i, .addr_parity_err_i,
  .data_parity_err_i, .master_busy_i, .master_abort_i, .target_abort_rcvd_i,
  .target_abort_sent_i, .perr_n_o, .perr_oe_o, .serr_n_o, .serr_oe_o, .status_o);
